// >>> design/cswp_pkg.sv
// Shared constants and types for the codec serial word port.
package cswp_pkg;
  // Master clock and shift clock timing.
  localparam int CLK_PERIOD_NS = 25;
  localparam int SCLK_HALF_NS = 100;
  localparam int SCLK_HALF_CYC = (SCLK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [2:0] PH_FALL = 3'(SCLK_HALF_CYC);
  localparam logic [2:0] PH_LAST = 3'(2 * SCLK_HALF_CYC - 1);
  localparam logic [2:0] PH_RISE = 3'h0;
  // Word layout.
  localparam int WORD_BITS = 16;
  localparam int SAMPLE_BITS = 14;
  localparam int FIFO_DEPTH = 16;
  localparam logic [3:0] BIT_FIRST = 4'h0;
  localparam logic [3:0] BIT_ADDR_DONE = 4'h7;
  localparam logic [3:0] BIT_LOW_BYTE = 4'h8;
  localparam logic [3:0] BIT_PRI_CTRL = 4'hE;
  localparam logic [3:0] BIT_LAST = 4'hF;
  localparam int PRI_CTRL_HI_POS = 1;
  localparam int PRI_CTRL_LO_POS = 0;
  localparam int SEC_CTRL_HI_POS = 15;
  localparam int SEC_CTRL_LO_POS = 14;
  localparam int SEC_RW_POS = 13;
  localparam int SEC_ADDR_MSB = 12;
  localparam int SEC_ADDR_LSB = 8;
  localparam int SEC_DATA_MSB = 7;
  // Partial-word positions after eight bits have arrived.
  localparam int HALF_RW_POS = 5;
  localparam int HALF_ADDR_MSB = 4;
  // Register addresses and values after reset.
  localparam logic [4:0] ADDR_NOOP = 5'h00;
  localparam logic [4:0] ADDR_FILTER_DIV = 5'h01;
  localparam logic [4:0] ADDR_RATE_DIV = 5'h02;
  localparam logic [4:0] ADDR_LAST = 5'h08;
  localparam logic [7:0] FILTER_DIV_RESET = 8'h12;
  localparam logic [7:0] RATE_DIV_RESET = 8'h12;
  localparam logic [7:0] DIV_MIN = 8'h01;
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  // Control-bit codes, shared by primary, secondary and hardware inputs.
  localparam logic [1:0] CTRL_NONE = 2'h0;
  localparam logic [1:0] CTRL_LATER = 2'h1;
  localparam logic [1:0] CTRL_EARLIER = 2'h2;
  localparam logic [1:0] CTRL_BOTH = 2'h3;

  typedef enum logic [0:0] {
    PORT_IDLE = 1'b0,
    PORT_SHIFT = 1'b1
  } cswp_state_t;
endpackage : cswp_pkg

// >>> design/cswp_port.sv
// Serial word port of the codec: shift engine, frame timing, config registers and DAC FIFO.
//
// How it works
// - Primary input word is a 14-bit DAC sample then two control bits.
// - Primary output word is the 14-bit ADC result with two zero LSBs.
// - Samples are two's complement about mid-scale; MSB one means below.
// - Both primary control bits high schedule a secondary word.
// - Secondary frame starts half a conversion period after the primary, floored.
// - Secondary word: two control bits, read/write, 5-bit address, 8-bit data.
// - Addresses one and two decode as the configuration registers.
// - A secondary word takes effect on the sixteenth falling shift edge; its read/write bit and read-back on the eighth.
// - Secondary codes 01, 10 and 11 decode like primary control bits, except that none of them schedules a secondary word.
// - Hardware control inputs count in secondary only with control bits 11.
// - Reset clears the read/write bit, so the port starts writing.
// - A read returns the register in the low byte, high byte zero.
// - A secondary write shifts out sixteen zeros.
// - A read ignores incoming data bits but still honours phase requests.
// - Address zero touches no register and reads back zero.
// - Filter clock is master clock divided by twice the filter divider.
// - Filter divider resets to eighteen.
// - Conversion rate is filter clock divided by the rate divider.
// - Rate divider resets to eighteen.
// - Secondary codes 01 and 10 shift phase; 00 blocks hardware shifts.
// - A secondary request may come from one source while the other shifts.
`timescale 1ns/1ps

module cswp_fifo
  import cswp_pkg::*;
#(
  parameter int WIDTH = SAMPLE_BITS,
  parameter int DEPTH = FIFO_DEPTH
) (
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic rst_n,
  // Filling side.
  input wire logic inValid,
  output logic inReady,
  input wire logic [WIDTH-1:0] inData,
  // Draining side.
  output logic outValid,
  input wire logic outReady,
  output logic [WIDTH-1:0] outData
);
  localparam int PTR_W = $clog2(DEPTH);
  localparam logic [PTR_W:0] PTR_ONE = (PTR_W + 1)'(1);
  localparam logic [PTR_W:0] PTR_ZERO = '0;

  logic [PTR_W:0] wrPtr;
  logic [PTR_W:0] rdPtr;
  logic [PTR_W:0] next_wrPtr;
  logic [PTR_W:0] next_rdPtr;
  logic [WIDTH-1:0] mem [DEPTH];
  logic push;
  logic pop;

  assign inReady = !((wrPtr[PTR_W] != rdPtr[PTR_W]) &&
                     (wrPtr[PTR_W-1:0] == rdPtr[PTR_W-1:0]));
  assign outValid = (wrPtr != rdPtr);
  assign outData = mem[rdPtr[PTR_W-1:0]];
  assign push = inValid && inReady;
  assign pop = outValid && outReady;

  always_comb begin
    next_wrPtr = push ? wrPtr + PTR_ONE : wrPtr;
    next_rdPtr = pop ? rdPtr + PTR_ONE : rdPtr;
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      wrPtr <= PTR_ZERO;
      rdPtr <= PTR_ZERO;
    end else begin
      wrPtr <= next_wrPtr;
      rdPtr <= next_rdPtr;
    end
  end

  for (genvar i = 0; i < DEPTH; i++) begin : gEntry
    always_ff @(posedge clk_sys) begin
      if (push && (wrPtr[PTR_W-1:0] == PTR_W'(i))) begin
        mem[i] <= inData;
      end
    end
  end
endmodule : cswp_fifo

module cswp_port
  import cswp_pkg::*;
(
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic rst_n,
  // Serial pins toward the host.
  output logic sclkOut,
  output logic frameSyncN,
  input wire logic dataIn,
  output logic dataOut,
  input wire logic hwFunctionCtrlHi,
  input wire logic hwFunctionCtrlLo,
  // Converter side.
  input wire logic [SAMPLE_BITS-1:0] adcResult,
  output logic dacValid,
  input wire logic dacReady,
  output logic [SAMPLE_BITS-1:0] dacSample,
  output logic filterClock,
  output logic convStrobe,
  output logic phaseEarlier,
  output logic phaseLater,
  // Configuration state.
  output logic [7:0] filterClockDivider,
  output logic [7:0] conversionRateDivider,
  output logic readWriteSelect
);
  // Returns {earlier, later, secondary request} from software and hardware codes.
  function automatic logic [2:0] decodeCtrl(input logic [1:0] sw, input logic [1:0] hw,
                                            input logic sec);
    logic [1:0] ph;
    logic req;
    ph = CTRL_NONE;
    req = 1'b0;
    unique case (sw)
      CTRL_NONE: begin
        if (!sec) begin
          ph = (hw == CTRL_BOTH) ? CTRL_NONE : hw;
          req = (hw == CTRL_BOTH);
        end
      end
      CTRL_LATER, CTRL_EARLIER: begin
        ph = sw;
        req = !sec && (hw == CTRL_BOTH);
      end
      CTRL_BOTH: begin
        ph = (hw == CTRL_BOTH) ? CTRL_NONE : hw;
        req = !sec;
      end
    endcase
    return {ph == CTRL_EARLIER, ph == CTRL_LATER, req};
  endfunction : decodeCtrl

  // Pin synchronisers.
  logic dinMeta;
  logic dinSync;
  logic fcHiMeta;
  logic fcHiSync;
  logic fcLoMeta;
  logic fcLoSync;

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      dinMeta <= 1'b0;
      dinSync <= 1'b0;
      fcHiMeta <= 1'b0;
      fcHiSync <= 1'b0;
      fcLoMeta <= 1'b0;
      fcLoSync <= 1'b0;
    end else begin
      dinMeta <= dataIn;
      dinSync <= dinMeta;
      fcHiMeta <= hwFunctionCtrlHi;
      fcHiSync <= fcHiMeta;
      fcLoMeta <= hwFunctionCtrlLo;
      fcLoSync <= fcLoMeta;
    end
  end

  // Port state.
  cswp_state_t state;
  cswp_state_t next_state;
  logic isSecondary;
  logic next_isSecondary;
  logic [3:0] bitCnt;
  logic [3:0] next_bitCnt;
  logic [2:0] phCnt;
  logic [2:0] next_phCnt;
  logic [WORD_BITS-1:0] shiftIn;
  logic [WORD_BITS-1:0] next_shiftIn;
  logic [WORD_BITS-1:0] shiftOut;
  logic [WORD_BITS-1:0] next_shiftOut;
  logic [7:0] halfCnt;
  logic [7:0] next_halfCnt;
  logic [7:0] convCnt;
  logic [7:0] next_convCnt;
  logic priPending;
  logic next_priPending;
  logic secArmed;
  logic next_secArmed;
  logic secPending;
  logic next_secPending;
  logic next_sclkOut;
  logic next_frameSyncN;
  logic next_dataOut;
  logic next_filterClock;
  logic next_convStrobe;
  logic next_phaseEarlier;
  logic next_phaseLater;
  logic [7:0] next_filterClockDivider;
  logic [7:0] next_conversionRateDivider;
  logic next_readWriteSelect;

  // Helpers read by the next-state logic.
  logic [7:0] filterEff;
  logic [7:0] rateEff;
  logic [7:0] secPoint;
  logic fclkTick;
  logic priDue;
  logic secDue;
  logic atFall;
  logic wordDone;
  logic [WORD_BITS-1:0] capWord;
  logic [4:0] halfAddr;
  logic [7:0] readByte;
  logic [2:0] ctrlDec;
  logic fifoInReady;
  logic fifoPush;

  assign filterEff = (filterClockDivider == BYTE_ZERO) ? DIV_MIN : filterClockDivider;
  assign rateEff = (conversionRateDivider == BYTE_ZERO) ? DIV_MIN : conversionRateDivider;
  // An odd rate divider lands half of one less, i.e. half a filter clock early.
  assign secPoint = rateEff[0] ? ((rateEff - DIV_MIN) >> 1) : (rateEff >> 1);
  assign atFall = (state == PORT_SHIFT) && (phCnt == PH_FALL);
  assign wordDone = atFall && (bitCnt == BIT_LAST);
  assign capWord = {shiftIn[WORD_BITS-2:0], dinSync};
  assign halfAddr = capWord[HALF_ADDR_MSB:0];
  assign fifoPush = wordDone && !isSecondary;

  // Read-back byte; the no-op and unimplemented addresses read as zero.
  always_comb begin
    unique case (halfAddr)
      ADDR_FILTER_DIV: readByte = filterClockDivider;
      ADDR_RATE_DIV: readByte = conversionRateDivider;
      default: readByte = BYTE_ZERO;
    endcase
  end

  always_comb begin
    ctrlDec = isSecondary ?
              decodeCtrl(capWord[SEC_CTRL_HI_POS:SEC_CTRL_LO_POS], {fcHiSync, fcLoSync}, 1'b1) :
              decodeCtrl(capWord[PRI_CTRL_HI_POS:PRI_CTRL_LO_POS], {fcHiSync, fcLoSync}, 1'b0);
  end

  // Frame timing: filter clock, conversion count and the secondary slot.
  always_comb begin
    next_filterClock = filterClock;
    next_halfCnt = halfCnt + DIV_MIN;
    fclkTick = 1'b0;
    if (halfCnt >= filterEff - DIV_MIN) begin
      next_halfCnt = BYTE_ZERO;
      next_filterClock = !filterClock;
      fclkTick = !filterClock;
    end
    // A new divider restarts the half-period count, so the half period in progress runs the new divider in full.
    if (next_filterClockDivider != filterClockDivider) begin
      next_halfCnt = BYTE_ZERO;
    end
    next_convCnt = convCnt;
    if (fclkTick) begin
      next_convCnt = (convCnt >= rateEff - DIV_MIN) ? BYTE_ZERO : convCnt + DIV_MIN;
    end
    priDue = fclkTick && (next_convCnt == BYTE_ZERO);
    secDue = fclkTick && (next_convCnt == secPoint);
    next_convStrobe = priDue;
  end

  // Shift engine, pending frames and register updates.
  always_comb begin
    next_state = state;
    next_isSecondary = isSecondary;
    next_bitCnt = bitCnt;
    next_phCnt = phCnt;
    next_shiftIn = shiftIn;
    next_shiftOut = shiftOut;
    next_sclkOut = sclkOut;
    next_frameSyncN = frameSyncN;
    next_dataOut = dataOut;
    next_phaseEarlier = 1'b0;
    next_phaseLater = 1'b0;
    next_filterClockDivider = filterClockDivider;
    next_conversionRateDivider = conversionRateDivider;
    next_readWriteSelect = readWriteSelect;
    next_priPending = priPending;
    next_secPending = secPending;
    next_secArmed = secArmed;
    unique case (state)
      PORT_IDLE: begin
        next_dataOut = 1'b0;
        if (secPending) begin
          next_state = PORT_SHIFT;
          next_isSecondary = 1'b1;
          next_secPending = 1'b0;
          next_shiftOut = '0;
          next_frameSyncN = 1'b0;
          next_bitCnt = BIT_FIRST;
          next_phCnt = PH_RISE;
        end else if (priPending && fifoInReady) begin
          next_state = PORT_SHIFT;
          next_isSecondary = 1'b0;
          next_priPending = 1'b0;
          next_shiftOut = {adcResult, 2'b00};
          next_frameSyncN = 1'b0;
          next_bitCnt = BIT_FIRST;
          next_phCnt = PH_RISE;
        end
      end
      PORT_SHIFT: begin
        next_phCnt = (phCnt == PH_LAST) ? PH_RISE : phCnt + 3'h1;
        if (phCnt == PH_RISE) begin
          next_sclkOut = 1'b1;
          next_dataOut = shiftOut[WORD_BITS-1];
          next_shiftOut = {shiftOut[WORD_BITS-2:0], 1'b0};
        end
        if (phCnt == PH_LAST) begin
          next_bitCnt = bitCnt + 4'h1;
        end
        if (atFall) begin
          next_sclkOut = 1'b0;
          next_shiftIn = capWord;
          if (isSecondary && (bitCnt == BIT_ADDR_DONE)) begin
            next_readWriteSelect = capWord[HALF_RW_POS];
            next_shiftOut[WORD_BITS-1:WORD_BITS-8] =
              capWord[HALF_RW_POS] ? readByte : BYTE_ZERO;
          end
        end
        if (wordDone) begin
          next_state = PORT_IDLE;
          next_frameSyncN = 1'b1;
          next_phaseEarlier = ctrlDec[2];
          next_phaseLater = ctrlDec[1];
          if (isSecondary && !readWriteSelect) begin
            // Data bits of a read are ignored; the phase request above still stands.
            unique case (capWord[SEC_ADDR_MSB:SEC_ADDR_LSB])
              ADDR_FILTER_DIV: next_filterClockDivider = capWord[SEC_DATA_MSB:0];
              ADDR_RATE_DIV: next_conversionRateDivider = capWord[SEC_DATA_MSB:0];
              default: next_filterClockDivider = filterClockDivider;
            endcase
          end
        end
      end
    endcase
    // Arrivals win over the clears made above.
    if (secDue) begin
      next_secPending = next_secPending || secArmed;
      next_secArmed = 1'b0;
    end
    if (wordDone && !isSecondary && ctrlDec[0]) begin
      next_secArmed = 1'b1;
    end
    if (priDue) begin
      next_priPending = 1'b1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      state <= PORT_IDLE;
      isSecondary <= 1'b0;
      bitCnt <= BIT_FIRST;
      phCnt <= PH_RISE;
      shiftIn <= '0;
      shiftOut <= '0;
      halfCnt <= BYTE_ZERO;
      convCnt <= BYTE_ZERO;
      priPending <= 1'b0;
      secArmed <= 1'b0;
      secPending <= 1'b0;
      sclkOut <= 1'b0;
      frameSyncN <= 1'b1;
      dataOut <= 1'b0;
      filterClock <= 1'b0;
      convStrobe <= 1'b0;
      phaseEarlier <= 1'b0;
      phaseLater <= 1'b0;
      filterClockDivider <= FILTER_DIV_RESET;
      conversionRateDivider <= RATE_DIV_RESET;
      readWriteSelect <= 1'b0;
    end else begin
      state <= next_state;
      isSecondary <= next_isSecondary;
      bitCnt <= next_bitCnt;
      phCnt <= next_phCnt;
      shiftIn <= next_shiftIn;
      shiftOut <= next_shiftOut;
      halfCnt <= next_halfCnt;
      convCnt <= next_convCnt;
      priPending <= next_priPending;
      secArmed <= next_secArmed;
      secPending <= next_secPending;
      sclkOut <= next_sclkOut;
      frameSyncN <= next_frameSyncN;
      dataOut <= next_dataOut;
      filterClock <= next_filterClock;
      convStrobe <= next_convStrobe;
      phaseEarlier <= next_phaseEarlier;
      phaseLater <= next_phaseLater;
      filterClockDivider <= next_filterClockDivider;
      conversionRateDivider <= next_conversionRateDivider;
      readWriteSelect <= next_readWriteSelect;
    end
  end

  // Received DAC samples wait here; a full FIFO holds back the next primary frame.
  cswp_fifo #(
    .WIDTH(SAMPLE_BITS),
    .DEPTH(FIFO_DEPTH)
  ) uDacFifo (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .inValid(fifoPush),
    .inReady(fifoInReady),
    .inData(capWord[WORD_BITS-1:WORD_BITS-SAMPLE_BITS]),
    .outValid(dacValid),
    .outReady(dacReady),
    .outData(dacSample)
  );

  // Checks.
  sequence secEndSeq;
    wordDone && isSecondary;
  endsequence

  sequence secSlotSeq;
    secDue && secArmed;
  endsequence

  a_pri_zero_lsbs: assert property (@(posedge clk_sys) disable iff (!rst_n)
    atFall && !isSecondary && (bitCnt >= BIT_PRI_CTRL) |-> !dataOut)
    else $error("Primary word low bits not zero.");

  a_sec_zero_high: assert property (@(posedge clk_sys) disable iff (!rst_n)
    atFall && isSecondary && (bitCnt < BIT_LOW_BYTE) |-> !dataOut)
    else $error("Secondary high byte not zero.");

  a_write_zero_out: assert property (@(posedge clk_sys) disable iff (!rst_n)
    atFall && isSecondary && (bitCnt >= BIT_LOW_BYTE) && !readWriteSelect |-> !dataOut)
    else $error("Write-mode secondary output not zero.");

  a_reset_values: assert property (@(posedge clk_sys) disable iff (!rst_n)
    $rose(rst_n) |-> (filterClockDivider == FILTER_DIV_RESET) &&
                     (conversionRateDivider == RATE_DIV_RESET) && !readWriteSelect)
    else $error("Register values after reset wrong.");

  a_write_filter_div: assert property (@(posedge clk_sys) disable iff (!rst_n)
    secEndSeq ##0 (!readWriteSelect && capWord[SEC_ADDR_MSB:SEC_ADDR_LSB] == ADDR_FILTER_DIV)
    |=> filterClockDivider == $past(capWord[SEC_DATA_MSB:0]))
    else $error("Filter divider not written at word end.");

  a_read_keeps_regs: assert property (@(posedge clk_sys) disable iff (!rst_n)
    secEndSeq ##0 readWriteSelect |=> $stable(filterClockDivider) &&
                                     $stable(conversionRateDivider))
    else $error("Read changed a register.");

  a_sec_slot_start: assert property (@(posedge clk_sys) disable iff (!rst_n)
    secSlotSeq ##1 (state == PORT_IDLE) |=> $fell(frameSyncN) && isSecondary)
    else $error("Secondary frame did not start at its slot.");

  a_filter_period: assert property (@(posedge clk_sys) disable iff (!rst_n)
    $changed(filterClock) |-> $past(halfCnt) == $past(filterEff) - DIV_MIN)
    else $error("Filter clock half period wrong.");

  a_noop_phase: assert property (@(posedge clk_sys) disable iff (!rst_n)
    secEndSeq ##0 (capWord[SEC_CTRL_HI_POS:SEC_CTRL_LO_POS] == CTRL_NONE)
    |=> !phaseEarlier && !phaseLater)
    else $error("Phase shift with secondary code 00.");

  a_frame_length: assert property (@(posedge clk_sys) disable iff (!rst_n)
    $fell(frameSyncN) |-> ##125 $rose(frameSyncN))
    else $error("Frame not sixteen shift clocks long.");
endmodule : cswp_port

// >>> verif/cswp_host_model.sv
// Behavioural host processor that exchanges one 16-bit word per serial frame.
`timescale 1ns/1ps

module cswp_host_model (
  // Serial pins of the port.
  input wire logic sclkOut,
  input wire logic frameSyncN,
  input wire logic dataOut,
  output logic dataIn
);
  logic [15:0] txQ[$];
  logic [15:0] rxQ[$];
  logic [15:0] txWord;
  logic [15:0] rxWord;
  logic queued;
  logic active;
  int bitNum;

  initial begin
    dataIn = 1'b0;
    queued = 1'b0;
    active = 1'b0;
    bitNum = 0;
  end

  // Frames with nothing queued send zeros and their answers are not kept.
  always @(negedge frameSyncN) begin
    queued = (txQ.size() > 0);
    txWord = queued ? txQ.pop_front() : 16'h0000;
    bitNum = 15;
    active = 1'b1;
    dataIn = txWord[15];
  end

  // The sixteenth bit closes the frame, since the sync rises in the same time step as it.
  // The line is not meaningful between frames, so it shows the inverse of the last bit.
  always @(negedge sclkOut) begin
    if (active) begin
      rxWord = {rxWord[14:0], dataOut};
      if (bitNum > 0) begin
        bitNum = bitNum - 1;
        dataIn = txWord[bitNum];
      end else begin
        active = 1'b0;
        dataIn = ~dataIn;
        if (queued) begin
          rxQ.push_back(rxWord);
        end
      end
    end
  end
endmodule : cswp_host_model

// >>> verif/test_codec_serial_word_port.sv
// Self-checking testbench for the codec serial word port.
`timescale 1ns/1ps

module test_codec_serial_word_port;
  import cswp_pkg::*;
  localparam logic [13:0] ADC_A = 14'h2C35;
  logic clk_sys, rst_n, sclkOut, frameSyncN, dataIn, dataOut;
  logic hwFunctionCtrlHi, hwFunctionCtrlLo, dacValid, dacReady, filterClock, convStrobe;
  logic phaseEarlier, phaseLater, readWriteSelect;
  logic [SAMPLE_BITS-1:0] adcResult, dacSample;
  logic [7:0] filterClockDivider, conversionRateDivider;
  int n_mismatch = 0;
  int n_compared = 0;
  int cyc = 0;
  int frameStart = 0;
  int nEarlier = 0;
  int nLater = 0;
  int curA = 18;
  int curB = 18;
  logic [1:0] phCtrl[5] = '{CTRL_NONE, CTRL_LATER, CTRL_EARLIER, CTRL_BOTH, CTRL_BOTH};
  logic [1:0] phHw[5] = '{CTRL_EARLIER, CTRL_NONE, CTRL_NONE, CTRL_LATER, CTRL_EARLIER};
  int phE[5] = '{0, 0, 1, 0, 1};
  int phL[5] = '{0, 1, 0, 1, 0};

  cswp_port dut_u (.clk_sys(clk_sys), .rst_n(rst_n), .sclkOut(sclkOut),
    .frameSyncN(frameSyncN), .dataIn(dataIn), .dataOut(dataOut),
    .hwFunctionCtrlHi(hwFunctionCtrlHi), .hwFunctionCtrlLo(hwFunctionCtrlLo),
    .adcResult(adcResult), .dacValid(dacValid), .dacReady(dacReady), .dacSample(dacSample),
    .filterClock(filterClock), .convStrobe(convStrobe), .phaseEarlier(phaseEarlier),
    .phaseLater(phaseLater), .filterClockDivider(filterClockDivider),
    .conversionRateDivider(conversionRateDivider), .readWriteSelect(readWriteSelect));
  cswp_host_model host_u (.sclkOut(sclkOut), .frameSyncN(frameSyncN), .dataOut(dataOut),
    .dataIn(dataIn));

  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end

  always @(posedge clk_sys) begin
    cyc++;
    if (phaseEarlier === 1'b1) nEarlier++;
    if (phaseLater === 1'b1) nLater++;
  end

  always @(negedge frameSyncN) frameStart = cyc;

  task automatic give_verdict;
    $display("Comparisons %0d, mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : give_verdict

  task automatic check(input string what, input logic [15:0] expv, input logic [15:0] seen);
    n_compared++;
    if (seen !== expv) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", what, expv, seen);
    end
  endtask : check

  task automatic tick;
    @(posedge clk_sys);
    #1;
  endtask : tick

  task automatic wait_rx(input string what, input logic [15:0] expRx);
    int i;
    for (i = 0; i < 3000 && host_u.rxQ.size() == 0; i++) @(posedge clk_sys);
    if (host_u.rxQ.size() == 0) begin
      check({what, " timeout"}, 16'h0001, 16'h0000);
      give_verdict();
    end else begin
      check(what, expRx, host_u.rxQ.pop_front());
    end
  endtask : wait_rx

  task automatic xfer(input string what, input logic [15:0] tx, input logic [15:0] expRx);
    host_u.txQ.push_back(tx);
    wait_rx(what, expRx);
  endtask : xfer

  function automatic logic probe(input bit sel);
    return sel ? convStrobe : filterClock;
  endfunction : probe

  // Cycles between rising edges; the first gap may straddle a divider change, so take the second.
  task automatic rise_gap(input bit sel, output int n);
    int i;
    repeat (2) begin
      n = 0;
      for (i = 0; i < 2000 && probe(sel) !== 1'b0; i++) tick();
      for (i = 0; i < 2000 && probe(sel) !== 1'b1; i++) tick();
      do begin tick(); n++; end while (n < 2000 && probe(sel) !== 1'b0);
      while (n < 2000 && probe(sel) !== 1'b1) begin tick(); n++; end
    end
  endtask : rise_gap

  // A primary asking for a secondary word, then the secondary word itself.
  task automatic sec(input string what, input logic [15:0] cmd, input logic [15:0] expRx,
                     input logic [1:0] hw, input int expE, input int expL);
    int e0;
    int l0;
    int p;
    xfer({what, " primary"}, {14'h1555, CTRL_BOTH}, {ADC_A, 2'b00});
    p = frameStart;
    @(posedge clk_sys);
    {hwFunctionCtrlHi, hwFunctionCtrlLo} <= hw;
    e0 = nEarlier;
    l0 = nLater;
    xfer(what, cmd, expRx);
    check({what, " slot"}, 16'((curB / 2) * 2 * curA), 16'(frameStart - p));
    repeat (3) tick();
    check({what, " earlier"}, 16'(expE), 16'(nEarlier - e0));
    check({what, " later"}, 16'(expL), 16'(nLater - l0));
    {hwFunctionCtrlHi, hwFunctionCtrlLo} <= 2'b00;
  endtask : sec

  initial begin
    int k;
    rst_n = 1'b0;
    hwFunctionCtrlHi = 1'b0;
    hwFunctionCtrlLo = 1'b0;
    adcResult = ADC_A;
    dacReady = 1'b1;
    repeat (2) @(posedge clk_sys);
    rst_n <= 1'b1;
    tick();
    check("A reset", 16'h0012, {8'h00, filterClockDivider});
    check("B reset", 16'h0012, {8'h00, conversionRateDivider});
    check("rw reset", 16'h0000, {15'h0000, readWriteSelect});
    // Fill the sample buffer until it holds back further primary frames, then drain it.
    host_u.txQ.push_back({14'h2000, CTRL_NONE});
    dacReady <= 1'b0;
    wait_rx("primary", {ADC_A, 2'b00});
    for (k = 1; k < FIFO_DEPTH; k++) begin
      xfer("primary", {14'(16'h2000 + k), CTRL_NONE}, {ADC_A, 2'b00});
    end
    host_u.txQ.push_back({14'h3FFF, CTRL_NONE});
    repeat (800) @(posedge clk_sys);
    check("held word", 16'h0001, 16'(host_u.txQ.size()));
    for (k = 0; k < FIFO_DEPTH; k++) begin
      tick();
      check("dac valid", 16'h0001, {15'h0000, dacValid});
      check("dac sample", {2'b00, 14'(16'h2000 + k)}, {2'b00, dacSample});
      dacReady <= 1'b1;
      @(posedge clk_sys);
      dacReady <= 1'b0;
    end
    tick();
    check("dac empty", 16'h0000, {15'h0000, dacValid});
    dacReady <= 1'b1;
    wait_rx("primary held", {ADC_A, 2'b00});
    sec("write A", {CTRL_NONE, 1'b0, ADDR_FILTER_DIV, 8'h09}, 16'h0000, 2'b00, 0, 0);
    curA = 9;
    check("A", 16'h0009, {8'h00, filterClockDivider});
    rise_gap(1'b0, k);
    check("filter period", 16'h0012, 16'(k));
    sec("write B", {CTRL_NONE, 1'b0, ADDR_RATE_DIV, 8'h15}, 16'h0000, 2'b00, 0, 0);
    curB = 21;
    check("B", 16'h0015, {8'h00, conversionRateDivider});
    rise_gap(1'b1, k);
    check("rate period", 16'h017A, 16'(k));
    sec("read A", {CTRL_NONE, 1'b1, ADDR_FILTER_DIV, 8'hFF}, 16'h0009, 2'b00, 0, 0);
    check("rw set", 16'h0001, {15'h0000, readWriteSelect});
    check("A kept", 16'h0009, {8'h00, filterClockDivider});
    sec("read B", {CTRL_NONE, 1'b1, ADDR_RATE_DIV, 8'h00}, 16'h0015, 2'b00, 0, 0);
    sec("read noop", {CTRL_NONE, 1'b1, ADDR_NOOP, 8'h00}, 16'h0000, 2'b00, 0, 0);
    sec("write noop", {CTRL_NONE, 1'b0, ADDR_NOOP, 8'hA5}, 16'h0000, 2'b00, 0, 0);
    check("B kept", 16'h0015, {8'h00, conversionRateDivider});
    check("rw clear", 16'h0000, {15'h0000, readWriteSelect});
    for (k = 0; k < 5; k++) begin
      sec("phase", {phCtrl[k], 1'(k % 2), ADDR_NOOP, 8'hA5}, 16'h0000, phHw[k], phE[k],
          phL[k]);
    end
    give_verdict();
  end
endmodule : test_codec_serial_word_port
